// *** logic/msc_cfg.svh ***
// Constants of the measured value fixed point scaler.
// Assumes inclusion by the package and every module of the block.
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH

// ****************************************************************
// Register map (byte addresses, 32-bit aligned words)
// ****************************************************************
`define MSC_ADDR_W          8
`define MSC_OFS_CTRL        8'h00
`define MSC_OFS_DIGITS      8'h04
`define MSC_OFS_STATUS      8'h08
`define MSC_OFS_COUNT       8'h0C
`define MSC_OFS_LAST0       8'h10
`define MSC_OFS_LAST3       8'h1C

// ****************************************************************
// Reset values and field layout
// ****************************************************************
`define MSC_CTRL_RST        1'h1
`define MSC_DIGITS_RST      8'h55
`define MSC_DIGIT_BAD       2'h3
`define MSC_CHANS           4
`define MSC_FIFO_DEPTH      4

// ****************************************************************
// Number formats and limits
// ****************************************************************
`define MSC_EXP_ZERO        8'h00
`define MSC_EXP_SPECIAL     8'hFF
`define MSC_EXP_UNITY       10'sh096
`define MSC_SHIFT_MAX       10'sh01F
`define MSC_LSHIFT_MAX      10'sh008
`define MSC_INT16_LIM       40'h00_0000_7D00
`define MSC_INT16_ERR       16'h7FFF
`define MSC_INT32_ERR       32'h7FFF_FFFF
`define MSC_CONV_MAX_DEG    40'h00_0000_07D0
`define MSC_CONV_MIN_DEG    40'h00_0000_012C
`define MSC_RESP_OKAY       2'h0
`define MSC_RESP_SLVERR     2'h2

`endif

// *** logic/msc_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`include "msc_cfg.svh"

module msc_fifo
    import msc_pkg::*;
#(
    parameter int WIDTH = 35,
    parameter int DEPTH = 4
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [2:0]            level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic             push;
    logic             pop;
    logic [2:0]       next_level;

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = mem[rptr];

    always_comb begin
        next_level = level;
        if (push && !pop) begin
            next_level = level + 3'h1;
        end else if (pop && !push) begin
            next_level = level - 3'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            if (push) begin
                wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + AW'(1);
            end
            if (pop) begin
                rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + AW'(1);
            end
        end
    end

    // Flags registered so both ports come straight from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level     <= 3'h0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            level     <= next_level;
            in_ready  <= (next_level != 3'(DEPTH));
            out_valid <= (next_level != 3'h0);
        end
    end

endmodule

// *** logic/msc_pkg.sv ***
// Types and shared arithmetic of the measured value scaler.
// Assumes msc_cfg.svh is on the include path.
`include "msc_cfg.svh"

package msc_pkg;

    typedef struct packed {
        logic [1:0]  chan;
        logic        err;
        logic [31:0] value;
    } msc_sample_s;

    typedef struct packed {
        logic [1:0]  chan;
        logic        err;
        logic        clamp;
        logic [15:0] int16;
        logic [31:0] int32;
        logic [31:0] flt;
    } msc_result_s;

    // Ten raised to the digit setting
    function automatic logic [6:0] msc_pow10(input logic [1:0] digits);
        unique case (digits)
            2'h0:    msc_pow10 = 7'h01;
            2'h1:    msc_pow10 = 7'h0A;
            default: msc_pow10 = 7'h64;
        endcase
    endfunction

endpackage

// *** logic/msc_round.sv ***
// Combinational float to scaled integer converter.
// Assumes a single precision input and a digit setting of 0 to 2.
`timescale 1ns/1ns
`include "msc_cfg.svh"

module msc_round
    import msc_pkg::*;
(
    input  wire logic [31:0] value,
    input  wire logic [1:0]  digits,
    input  wire logic        err,
    output logic [15:0]      int16,
    output logic [31:0]      int32,
    output logic             clamp
);
    logic               neg;
    logic [7:0]         expo;
    logic [6:0]         p10;
    logic [30:0]        prod;
    logic signed [9:0]  k;
    logic [39:0]        mag;
    logic               big;
    logic [39:0]        lim_hi;
    logic [39:0]        lim_lo;
    logic [39:0]        lim32;
    logic [39:0]        lim16;
    logic               sat32;
    logic               sat16;
    logic               bad;

    always_comb begin
        neg    = value[31];
        expo   = value[30:23];
        p10    = msc_pow10(digits);
        // Scale by ten to the digit setting before rounding [RULE_02] [RULE_03]
        prod   = {7'h00, 1'b1, value[22:0]} * 31'(p10);
        k      = `MSC_EXP_UNITY - $signed({2'b00, expo});
        mag    = '0;
        big    = 1'b0;
        if (expo == `MSC_EXP_ZERO || k > `MSC_SHIFT_MAX) begin
            mag = '0;
        end else if (k > 10'sh000) begin
            // Round half away from zero on the magnitude [RULE_05] [RULE_11]
            mag = ({9'h0, prod} + (40'h1 << (k - 10'sh001))) >> k;
        end else if (k >= -`MSC_LSHIFT_MAX) begin
            mag = {9'h0, prod} << (-k);
        end else begin
            big = 1'b1;
        end
        lim_hi = 40'(`MSC_CONV_MAX_DEG * p10);
        lim_lo = 40'(`MSC_CONV_MIN_DEG * p10);
        lim32  = neg ? lim_lo : lim_hi;
        lim16  = `MSC_INT16_LIM;
        sat32  = big || (mag > lim32);
        sat16  = big || (mag > lim16);
        bad    = err || (expo == `MSC_EXP_SPECIAL);
        clamp  = !bad && (sat16 || sat32);
        if (bad) begin
            // Fixed sentinels, never clamped [RULE_10]
            int16 = `MSC_INT16_ERR;
            int32 = `MSC_INT32_ERR;
        end else begin
            // Out of range takes the nearer limit [RULE_06]
            int32 = sat32 ? 32'(lim32) : mag[31:0];
            int16 = sat16 ? lim16[15:0] : mag[15:0];
            if (neg) begin
                int32 = -int32;
                int16 = -int16;
            end
        end
    end

endmodule

// *** logic/msc_scaler.sv ***
// Measured value fixed point scaler with AXI4-Lite settings.
// Assumes an upstream stage that computes each float temperature.
//
// Notes on behaviour
// [RULE_01] Integer outputs derive from the float value
// [RULE_02] 16-bit output is value times ten-power
// [RULE_03] 32-bit output is value times ten-power
// [RULE_04] Float output passes through unchanged
// [RULE_05] Lost digits round to nearest, both widths
// [RULE_06] Out-of-range result takes nearer limit
// [RULE_07] Per-channel digits 0..2, default one
// [RULE_08] Digits affect only the integer outputs
// [RULE_09] Settings apply live, no restart needed
// [RULE_10] Error gives maximum positive sentinels, unclamped
// [RULE_11] Halves round away from zero symmetrically
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "msc_cfg.svh"

module msc_scaler
    import msc_pkg::*;
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [`MSC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]             s_axi_awprot,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`MSC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]             s_axi_arprot,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   in_valid,
    output logic                        in_ready,
    input  wire msc_sample_s            in_sample,
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output msc_result_s                 out_result
);

    // ************************************************************
    // Register state
    // ************************************************************
    logic                   enable;
    logic [7:0]             chan_fraction_digits;
    logic [3:0]             clamp_flags;
    logic [3:0]             err_flags;
    logic [31:0]            conv_count;
    logic [31:0]            last_int32 [`MSC_CHANS];

    logic                   aw_held;
    logic [`MSC_ADDR_W-1:0] aw_addr;
    logic                   w_held;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   do_write;
    logic                   wr_ctrl;
    logic                   wr_digits;
    logic                   wr_status;
    logic                   wr_hit;
    logic [3:0]             clr_clamp;
    logic [3:0]             clr_err;
    logic [31:0]            next_rdata;
    logic [1:0]             next_rresp;

    // ************************************************************
    // Datapath signals
    // ************************************************************
    msc_sample_s            fifo_data;
    logic                   fifo_valid;
    logic                   fifo_pop;
    logic [2:0]             fifo_level;
    logic [1:0]             cur_digits;
    logic [15:0]            conv_int16;
    logic [31:0]            conv_int32;
    logic                   conv_clamp;
    logic [3:0]             set_clamp;
    logic [3:0]             set_err;

    // Decodes a byte address to a mapped register
    function automatic logic addr_hit(input logic [`MSC_ADDR_W-1:0] a,
                                      input logic [`MSC_ADDR_W-1:0] ofs);
        addr_hit = (a[`MSC_ADDR_W-1:2] == ofs[`MSC_ADDR_W-1:2]);
    endfunction

    // Keeps a field when software asks for an illegal digit count
    function automatic logic [1:0] legal_digit(input logic [1:0] nv,
                                               input logic [1:0] ov);
        legal_digit = (nv == `MSC_DIGIT_BAD) ? ov : nv;
    endfunction

    // ************************************************************
    // Input buffer
    // ************************************************************
    // Conversion stalls when disabled, so the buffer fills and
    // in_ready drops toward the source
    msc_fifo #(
        .WIDTH ($bits(msc_sample_s)),
        .DEPTH (`MSC_FIFO_DEPTH)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   (in_sample),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data),
        .level     (fifo_level)
    );

    assign fifo_pop = fifo_valid && enable && (!out_valid || out_ready);

    // ************************************************************
    // Conversion
    // ************************************************************
    // Digit setting read live for each sample [RULE_09]
    assign cur_digits = chan_fraction_digits[fifo_data.chan * 2 +: 2];

    // Integer words derive from the float sample only [RULE_01]
    msc_round u_round (
        .value  (fifo_data.value),
        .digits (cur_digits),
        .err    (fifo_data.err),
        .int16  (conv_int16),
        .int32  (conv_int32),
        .clamp  (conv_clamp)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_valid  <= 1'b0;
            out_result <= '0;
        end else if (fifo_pop) begin
            out_valid        <= 1'b1;
            out_result.chan  <= fifo_data.chan;
            out_result.err   <= fifo_data.err;
            out_result.clamp <= conv_clamp;
            out_result.int16 <= conv_int16;   // [RULE_02] [RULE_05]
            out_result.int32 <= conv_int32;   // [RULE_03] [RULE_05]
            // Float untouched by any digit setting [RULE_04] [RULE_08]
            out_result.flt   <= fifo_data.value;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_count <= 32'h0000_0000;
        end else if (fifo_pop) begin
            conv_count <= conv_count + 32'h0000_0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < `MSC_CHANS; i++) begin
                last_int32[i] <= 32'h0000_0000;
            end
        end else if (fifo_pop) begin
            last_int32[fifo_data.chan] <= conv_int32;
        end
    end

    // ************************************************************
    // Sticky status
    // ************************************************************
    always_comb begin
        set_clamp = 4'h0;
        set_err   = 4'h0;
        if (fifo_pop) begin
            set_clamp[fifo_data.chan] = conv_clamp;
            set_err[fifo_data.chan]   = fifo_data.err;
        end
    end

    assign clr_clamp = wr_status ? w_data[3:0] : 4'h0;
    assign clr_err   = wr_status ? w_data[7:4] : 4'h0;

    // A new event wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clamp_flags <= 4'h0;
            err_flags   <= 4'h0;
        end else begin
            clamp_flags <= (clamp_flags & ~clr_clamp) | set_clamp;
            err_flags   <= (err_flags & ~clr_err) | set_err;
        end
    end

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    assign do_write  = aw_held && w_held && !s_axi_bvalid;
    assign wr_ctrl   = do_write && w_strb[0]
                       && addr_hit(aw_addr, `MSC_OFS_CTRL);
    assign wr_digits = do_write && w_strb[0]
                       && addr_hit(aw_addr, `MSC_OFS_DIGITS);
    assign wr_status = do_write && w_strb[0]
                       && addr_hit(aw_addr, `MSC_OFS_STATUS);
    assign wr_hit    = addr_hit(aw_addr, `MSC_OFS_CTRL)
                       || addr_hit(aw_addr, `MSC_OFS_DIGITS)
                       || addr_hit(aw_addr, `MSC_OFS_STATUS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            aw_addr       <= '0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held       <= 1'b0;
            s_axi_awready <= 1'b1;
        end else if (!aw_held) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held       <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (!w_held) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `MSC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `MSC_RESP_OKAY : `MSC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable <= `MSC_CTRL_RST;
        end else if (wr_ctrl) begin
            enable <= w_data[0];
        end
    end

    // Each channel keeps its own digit count, default one [RULE_07]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_fraction_digits <= `MSC_DIGITS_RST;
        end else if (wr_digits) begin
            for (int c = 0; c < `MSC_CHANS; c++) begin
                chan_fraction_digits[c*2 +: 2] <=
                    legal_digit(w_data[c*2 +: 2],
                                chan_fraction_digits[c*2 +: 2]);
            end
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = `MSC_RESP_OKAY;
        if (addr_hit(s_axi_araddr, `MSC_OFS_CTRL)) begin
            next_rdata[0] = enable;
        end else if (addr_hit(s_axi_araddr, `MSC_OFS_DIGITS)) begin
            next_rdata[7:0] = chan_fraction_digits;
        end else if (addr_hit(s_axi_araddr, `MSC_OFS_STATUS)) begin
            next_rdata[3:0]  = clamp_flags;
            next_rdata[7:4]  = err_flags;
            next_rdata[10:8] = fifo_level;
        end else if (addr_hit(s_axi_araddr, `MSC_OFS_COUNT)) begin
            next_rdata = conv_count;
        end else if (s_axi_araddr >= `MSC_OFS_LAST0
                     && s_axi_araddr <= `MSC_OFS_LAST3 + 8'h03) begin
            next_rdata = last_int32[s_axi_araddr[3:2]];
        end else begin
            next_rresp = `MSC_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `MSC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// *** verification/msc_scaler_checker.sv ***
// Concurrent checks on the scaler's ports.
// Assumes msc_pkg is compiled first.
`timescale 1ns/1ns
module msc_scaler_checker
    import msc_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire msc_result_s out_result
);
    // ********************
    // Properties
    // ********************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Sentinels of err-flagged samples are exempt from range limits; special-exponent sentinels are not
    wire good = out_valid && !out_result.err;

    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read not answered");
    a_result_hold: assert property (out_valid && !out_ready
        |=> out_valid && $stable(out_result)) else $error("result moved");
    a_err_sentinel: assert property (out_valid && out_result.err
        |-> out_result.int16 == 16'h7FFF && !out_result.clamp
        && out_result.int32 == 32'h7FFF_FFFF) else $error("bad sentinel");
    a_int16_range: assert property (good |->
        $signed(out_result.int16) >= -32000
        && $signed(out_result.int16) <= 32000) else $error("int16 range");
    a_width_agree: assert property (good && !out_result.clamp
        |-> out_result.int16 == out_result.int32[15:0])
        else $error("widths differ");
    a_sign_follow: assert property (good && out_result.flt[31]
        |-> out_result.int32[31] || out_result.int32 == 32'h0000_0000)
        else $error("sign lost");
endmodule

bind msc_scaler msc_scaler_checker i_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .out_valid(out_valid),
    .out_ready(out_ready), .out_result(out_result)
);

// *** verification/tb_top.sv ***
// Self-checking bench for the scaler.
// Assumes the design files compile first.
`timescale 1ns/1ns
`include "msc_cfg.svh"
module tb_top;
    import msc_pkg::*;
    // ********************
    // Ports
    // ********************
    logic        aclk = 0, aresetn = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic        awvalid = 0, wvalid = 0, arvalid = 0, bready = 1;
    logic        rready = 1, in_valid = 0, out_ready = 0;
    logic        awready, wready, arready, bvalid, rvalid, in_ready, out_valid;
    logic [1:0]  bresp, rresp;
    msc_sample_s in_sample = '0;
    msc_result_s res;
    int          errors = 0, total_checks = 0;

    always #4 aclk = ~aclk;

    msc_scaler i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .in_valid(in_valid), .in_ready(in_ready),
        .in_sample(in_sample), .out_valid(out_valid),
        .out_ready(out_ready), .out_result(res)
    );

    // ********************
    // Tasks
    // ********************
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bounded wait edge
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 300) begin
            errors++;
            $display("MISMATCH wait expected answer seen none");
            test_done();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        do begin
            tick(n);
            if (awready && awvalid) awvalid <= 0;
            if (wready && wvalid) wvalid <= 0;
        end while (!bvalid);
        chk("bresp", 32'(bresp), 32'(r));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int n = 0;
        araddr <= a;
        arvalid <= 1;
        do begin
            tick(n);
            if (arready && arvalid) arvalid <= 0;
        end while (!rvalid);
        chk("rdata", rdata, d);
        chk("rresp", 32'(rresp), 32'(r));
    endtask

    task automatic conv(input logic [1:0] ch, input logic e,
                        input logic [31:0] v, input logic [15:0] e16,
                        input logic [31:0] e32, input logic ec);
        int n = 0;
        in_sample <= '{ch, e, v};
        in_valid <= 1;
        out_ready <= 1;
        do begin
            tick(n);
            if (in_ready) in_valid <= 0;
        end while (!out_valid);
        out_ready <= 0;
        chk("int16", 32'(res.int16), 32'(e16));
        chk("int32", res.int32, e32);
        chk("clamp", 32'(res.clamp), 32'(ec));
        chk("flt", res.flt, v);
        chk("chan", 32'(res.chan), 32'(ch));
        @(posedge aclk);
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic test_reset;
        rd(`MSC_OFS_CTRL, 32'h0000_0001, `MSC_RESP_OKAY);
        rd(`MSC_OFS_DIGITS, 32'h0000_0055, `MSC_RESP_OKAY);
        rd(8'h40, 32'h0000_0000, `MSC_RESP_SLVERR);
        conv(2'h0, 0, 32'h3FA0_0000, 16'h000D, 32'h0000_000D, 0);
        $display("test reset done");
    endtask

    task automatic test_digits;
        wr(`MSC_OFS_DIGITS, 32'h0000_0024, `MSC_RESP_OKAY);
        wr(`MSC_OFS_DIGITS, 32'h0000_00E4, `MSC_RESP_OKAY);
        rd(`MSC_OFS_DIGITS, 32'h0000_0024, `MSC_RESP_OKAY);
        wr(8'h44, 32'h0000_0000, `MSC_RESP_SLVERR);
        conv(2'h0, 0, 32'h3FBA_1CAC, 16'h0001, 32'h0000_0001, 0);
        conv(2'h1, 0, 32'h3FBA_1CAC, 16'h000F, 32'h0000_000F, 0);
        conv(2'h2, 0, 32'h3FBA_1CAC, 16'h0091, 32'h0000_0091, 0);
        conv(2'h0, 0, 32'h4020_0000, 16'h0003, 32'h0000_0003, 0);
        conv(2'h0, 0, 32'hC020_0000, 16'hFFFD, 32'hFFFF_FFFD, 0);
        conv(2'h3, 0, 32'h0000_0000, 16'h0000, 32'h0000_0000, 0);
        conv(2'h2, 0, 32'h447A_0000, 16'h7D00, 32'h0001_86A0, 1);
        conv(2'h1, 0, 32'h451C_4000, 16'h61A8, 32'h0000_4E20, 1);
        conv(2'h1, 1, 32'h447A_0000, 16'h7FFF, 32'h7FFF_FFFF, 0);
        conv(2'h2, 0, 32'hC3C8_0000, 16'h8300, 32'hFFFF_8AD0, 1);
        rd(`MSC_OFS_LAST0 + 8'h08, 32'hFFFF_8AD0, `MSC_RESP_OKAY);
        $display("test digits done");
    endtask

    task automatic test_fifo;
        logic [15:0] e16 [4] = '{16'h0001, 16'h000D, 16'h007D, 16'h0001};
        int n = 0, k = 0;
        wr(`MSC_OFS_STATUS, 32'h0000_00FF, `MSC_RESP_OKAY);
        wr(`MSC_OFS_CTRL, 32'h0000_0000, `MSC_RESP_OKAY);
        in_sample <= '{2'h0, 1'b0, 32'h3FA0_0000};
        in_valid <= 1;
        while (k < 8) begin
            tick(n);
            if (!in_ready) break;
            k++;
            in_sample.chan <= 2'(k);
        end
        in_valid <= 0;
        chk("pushes", k, `MSC_FIFO_DEPTH);
        rd(`MSC_OFS_STATUS, 32'h0000_0400, `MSC_RESP_OKAY);
        wr(`MSC_OFS_CTRL, 32'h0000_0001, `MSC_RESP_OKAY);
        do tick(n); while (!out_valid);
        repeat (3) @(posedge aclk);
        chk("stall valid", 32'(out_valid), 1);
        out_ready <= 1;
        k = 0;
        while (k < 4) begin
            tick(n);
            if (out_valid) begin
                chk("order", 32'(res.chan), 32'(k));
                chk("fifo int16", 32'(res.int16), 32'(e16[k]));
                k++;
            end
        end
        out_ready <= 0;
        $display("test fifo done");
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        test_reset();
        test_digits();
        test_fifo();
        test_done();
    end
endmodule
